// ==== src/pmc_ctrl.sv ====
// performance monitor control register, cycle counter and event counter control
`timescale 1ns/1ps
`default_nettype none
module pmc_ctrl
#(
  parameter bit         HYP_IMPL         = 1'b1,  // hypervisor level present
  parameter bit         EVBUS_IMPL       = 1'b1,  // event export bus present
  parameter logic [7:0] IMPLEMENTER_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] PART_IDENT_CODE  = 8'hA5, // arbitrary value
  parameter logic [4:0] NUM_COUNTERS     = 5'h1F  // implemented event counters
)
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        cp_valid,
  input  wire logic        cp_write,
  input  wire logic [3:0]  cp_coproc,
  input  wire logic [2:0]  cp_opc1,
  input  wire logic [3:0]  cp_crn,
  input  wire logic [3:0]  cp_crm,
  input  wire logic [2:0]  cp_opc2,
  input  wire logic [1:0]  cp_el,
  input  wire logic [31:0] cp_wdata,
  output var  logic        cp_done,
  output var  logic [31:0] cp_rdata,
  output var  logic        cp_trap_undef,
  output var  logic        cp_trap_hyp,
  input  wire logic        ext_wr,
  input  wire logic [6:0]  ext_wdata,
  output var  logic [6:0]  ext_rdata,
  input  wire logic        user_access_enable,
  input  wire logic        hyp_trap_monitor_access,
  input  wire logic        hyp_trap_control_access,
  input  wire logic        hyp_trap_primary_nine,
  input  wire logic [4:0]  hyp_counter_partition,
  input  wire logic        hyp_prohibit_counting,
  input  wire logic        count_prohibit,
  input  wire logic [31:0] counter_enable_set,
  input  wire logic [30:0] event_pulse,
  input  wire logic [31:0] overflow_clear,
  input  wire logic [4:0]  evt_rd_idx,
  output var  logic [31:0] evt_rd_data,
  output var  logic [63:0] cycle_counter,
  output var  logic [31:0] overflow_status,
  output var  logic [30:0] event_export
);
  pmc_bank_if bank_bus ();  // link to the counter bank

  // state registers
  logic [6:0]  ctrl_r;       // long-cycle, dp, export, divider, 0, 0, enable
  logic [6:0]  ctrl_nxt;
  logic [63:0] cc_r;         // cycle counter
  logic [63:0] cc_nxt;
  logic [5:0]  presc_r;      // divide-by-64 prescaler
  logic [31:0] ovf_r;        // overflow status flags
  logic [30:0] export_r;     // exported event pulses
  logic [31:0] rdata_r;
  logic        done_r;
  logic        undef_r;
  logic        hyp_r;
  logic [6:0]  ext_rd_r;

  // access decode
  wire enc_hit = cp_valid && cp_coproc == pmc_pkg::CP_COPROC && cp_opc1 == pmc_pkg::CP_OPC1
                 && cp_crn == pmc_pkg::CP_CRN && cp_crm == pmc_pkg::CP_CRM
                 && cp_opc2 == pmc_pkg::CP_OPC2;
  wire lower_el  = (cp_el != pmc_pkg::EL_HYP);
  // an unknown encoding is answered as undefined so the core never hangs
  wire trap_undef = cp_valid && (!enc_hit || (cp_el == pmc_pkg::EL_USER
                    && !user_access_enable));
  wire trap_hyp   = enc_hit && !trap_undef && HYP_IMPL && lower_el
                    && (hyp_trap_monitor_access || hyp_trap_control_access
                    || hyp_trap_primary_nine);
  wire acc_ok = enc_hit && !trap_undef && !trap_hyp;
  wire cp_wr  = acc_ok && cp_write;
  wire cp_rd  = acc_ok && !cp_write;

  // shared low bits: core write wins over a debug write in the same cycle
  wire       ctrl_wen   = cp_wr || ext_wr;
  wire [6:0] ctrl_wdata = cp_wr ? cp_wdata[6:0] : ext_wdata;
  wire [6:0] ctrl_wmask = {1'b1, HYP_IMPL, EVBUS_IMPL, 1'b1, 1'b0, 1'b0, 1'b1};
  assign ctrl_nxt = ctrl_wen ? (ctrl_wdata & ctrl_wmask) : ctrl_r;

  wire lc = ctrl_r[pmc_pkg::LC_BIT];
  wire dp = ctrl_r[pmc_pkg::DP_BIT];
  wire xe = ctrl_r[pmc_pkg::X_BIT];
  wire dv = ctrl_r[pmc_pkg::D_BIT];
  wire en = ctrl_r[pmc_pkg::E_BIT];

  // clear strobes; a debug write acts with full scope like the hypervisor
  wire cyc_clear = ctrl_wen && ctrl_wdata[pmc_pkg::C_BIT];
  wire evt_clear = ctrl_wen && ctrl_wdata[pmc_pkg::P_BIT];
  wire clr_lower = cp_wr && lower_el && HYP_IMPL;

  // per event counter masks
  logic [30:0] impl_m;
  logic [30:0] part_m;
  logic [30:0] prohib_m;
  logic [30:0] run_m;
  genvar gi;
  generate
    for (gi = 0; gi < pmc_pkg::NUM_EVT; gi++)
    begin : g_evt
      assign impl_m[gi]   = pmc_pkg::below_partition(5'(gi), NUM_COUNTERS);
      assign part_m[gi]   = pmc_pkg::below_partition(5'(gi), hyp_counter_partition);
      // the hypervisor prohibition blocks partitioned counters only while the global enable is set
      assign prohib_m[gi] = count_prohibit || (HYP_IMPL && hyp_prohibit_counting
                            && en && part_m[gi]);
      // reserved counters ignore the global enable
      assign run_m[gi]    = impl_m[gi] && counter_enable_set[gi] && !prohib_m[gi]
                            && (en || (HYP_IMPL && !part_m[gi]));
      assign bank_bus.clr[gi] = evt_clear && impl_m[gi]
                                && (!clr_lower || part_m[gi]);
    end
  endgenerate
  assign bank_bus.inc    = run_m & event_pulse;
  assign bank_bus.rd_idx = evt_rd_idx;

  // cycle counter control
  wire cyc_prohib = count_prohibit || (HYP_IMPL && hyp_prohibit_counting && en);
  wire cyc_run    = en && counter_enable_set[31] && !(dp && cyc_prohib);
  // long-cycle overrides the divider, so the prescaler has no effect then
  wire cyc_tick   = lc || !dv || (presc_r == pmc_pkg::PRESC_LAST);
  wire cyc_inc    = cyc_run && cyc_tick;
  wire [63:0] cc_plus = cc_r + 64'h1;
  wire cyc_wrap   = lc ? (cc_r[63] && !cc_plus[63]) : (cc_r[31] && !cc_plus[31]);
  wire cyc_ovf    = cyc_inc && !cyc_clear && cyc_wrap;
  assign cc_nxt   = cyc_clear ? 64'h0 : (cyc_inc ? cc_plus : cc_r);

  // overflow flags: hardware set beats a software clear; the clear strobes leave them
  // alone, and the export bit is deliberately absent from this path
  wire [31:0] ovf_set = {cyc_ovf, bank_bus.ovf};
  wire [31:0] ovf_nxt = ovf_set | (ovf_r & ~overflow_clear);

  // event export gated by enable and prohibition
  wire [30:0] export_nxt = (EVBUS_IMPL && xe) ? (event_pulse & impl_m & ~prohib_m)
                           : 31'h0;

  // read data; clear bits are never stored, so they read as zero
  wire [4:0]  n_read   = (HYP_IMPL && lower_el) ? hyp_counter_partition : NUM_COUNTERS;
  wire [31:0] rd_value = {IMPLEMENTER_CODE, PART_IDENT_CODE, n_read, 4'h0, ctrl_r};

  // control bits and debug mirror
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ctrl_r   <= pmc_pkg::CTRL_RST;
      ext_rd_r <= pmc_pkg::CTRL_RST;
    end
    else
    begin
      ctrl_r   <= ctrl_nxt;
      ext_rd_r <= ctrl_nxt;
    end
  end

  // cycle counter and prescaler; prescaler only moves while counting is on
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cc_r    <= 64'h0;
      presc_r <= 6'h0;
    end
    else
    begin
      cc_r    <= cc_nxt;
      presc_r <= cyc_run ? presc_r + 6'h1 : presc_r;
    end
  end

  // status and export registers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ovf_r    <= 32'h0;
      export_r <= 31'h0;
    end
    else
    begin
      ovf_r    <= ovf_nxt;
      export_r <= export_nxt;
    end
  end

  // access answer, one cycle after the request
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rdata_r <= 32'h0;
      done_r  <= 1'b0;
      undef_r <= 1'b0;
      hyp_r   <= 1'b0;
    end
    else
    begin
      rdata_r <= cp_rd ? rd_value : 32'h0;
      done_r  <= cp_valid;
      undef_r <= trap_undef;
      hyp_r   <= trap_hyp;
    end
  end

  pmc_event_bank u_bank
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .bus     (bank_bus)
  );

  assign cp_done         = done_r;
  assign cp_rdata        = rdata_r;
  assign cp_trap_undef   = undef_r;
  assign cp_trap_hyp     = hyp_r;
  assign ext_rdata       = ext_rd_r;
  assign evt_rd_data     = bank_bus.rd_data;
  assign cycle_counter   = cc_r;
  assign overflow_status = ovf_r;
  assign event_export    = export_r;

  // checks
  // implementer field on every successful read
  imp_field_a: assert property (@(posedge clk_sys) disable iff (reset)
    $past(cp_rd) |-> cp_rdata[31:24] == IMPLEMENTER_CODE)
    else $error("implementer code wrong");
  // identification field on every successful read
  id_field_a: assert property (@(posedge clk_sys) disable iff (reset)
    $past(cp_rd) |-> cp_rdata[23:16] == PART_IDENT_CODE)
    else $error("identification code wrong");
  // lower levels see the partition, not the implemented count
  n_partition_a: assert property (@(posedge clk_sys) disable iff (reset)
    cp_rd && lower_el && HYP_IMPL |=> cp_rdata[15:11] == $past(hyp_counter_partition))
    else $error("lower level count not partition");
  // short overflow flags the bit 31 wrap
  wrap_low_a: assert property (@(posedge clk_sys) disable iff (reset)
    cyc_inc && !lc && !cyc_clear && cc_r[31:0] == 32'hFFFFFFFF |=> overflow_status[31])
    else $error("cycle overflow at bit 31 missed");
  // cycle counter frozen while prohibited with dp set
  dp_stop_a: assert property (@(posedge clk_sys) disable iff (reset)
    dp && cyc_prohib && !cyc_clear |=> cycle_counter == $past(cycle_counter))
    else $error("cycle counter ran while prohibited");
  // export bit off means a silent event bus
  x_off_a: assert property (@(posedge clk_sys) disable iff (reset)
    !xe |=> event_export == 31'h0)
    else $error("event exported while export off");
  // count_prohibit silences the whole event bus
  no_export_a: assert property (@(posedge clk_sys) disable iff (reset)
    count_prohibit |=> event_export == 31'h0)
    else $error("event exported while prohibited");
  // divided ticks only on the last prescaler step
  div_tick_a: assert property (@(posedge clk_sys) disable iff (reset)
    cyc_inc && dv && !lc |-> presc_r == pmc_pkg::PRESC_LAST)
    else $error("divided cycle tick off phase");
  // long cycle mode counts every running clock
  lc_every_a: assert property (@(posedge clk_sys) disable iff (reset)
    cyc_run && lc && !cyc_clear |=> cycle_counter == $past(cycle_counter) + 64'h1)
    else $error("long cycle count skipped");
  // cycle clear lands next edge, clear bits never read back
  cyc_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
    cyc_clear |=> cycle_counter == 64'h0 ##1 cp_rdata[2:1] == 2'h0)
    else $error("cycle clear failed");
  // cycle clear leaves the cycle overflow flag alone
  clr_keeps_a: assert property (@(posedge clk_sys) disable iff (reset)
    cyc_clear && !overflow_clear[31] |=> overflow_status[31] == $past(ovf_r[31]))
    else $error("cycle clear touched overflow");
  // global enable off holds the cycle counter
  cyc_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    !en && !cyc_clear |=> cycle_counter == $past(cycle_counter))
    else $error("cycle counter ran with enable off");
  // user access without permission is undefined, never a hyp trap
  user_trap_a: assert property (@(posedge clk_sys) disable iff (reset)
    enc_hit && cp_el == pmc_pkg::EL_USER && !user_access_enable
    |=> cp_trap_undef && !cp_trap_hyp)
    else $error("user access not trapped");
  // a trapped access must not change the control bits
  trap_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
    (trap_undef || trap_hyp) && !ext_wr |=> ctrl_r == $past(ctrl_r))
    else $error("trapped access changed control");
  // debug copy tracks the low control bits
  debug_copy_a: assert property (@(posedge clk_sys) disable iff (reset)
    ext_rdata == ctrl_r)
    else $error("debug copy diverged");
endmodule
`default_nettype wire

// ==== src/pmc_pkg.sv ====
// constants, field layout and helpers shared by the performance monitor control block
package pmc_pkg;
  // coprocessor transfer encoding that selects the control register
  localparam logic [3:0] CP_COPROC   = 4'hF;
  localparam logic [2:0] CP_OPC1     = 3'h0;
  localparam logic [3:0] CP_CRN      = 4'h9;
  localparam logic [3:0] CP_CRM      = 4'hC;
  localparam logic [2:0] CP_OPC2     = 3'h0;
  // privilege levels as presented on the access port
  localparam logic [1:0] EL_USER     = 2'h0;
  localparam logic [1:0] EL_KERNEL   = 2'h1;
  localparam logic [1:0] EL_HYP      = 2'h2;
  // field positions of the control register
  localparam int IMP_LSB   = 24;
  localparam int ID_LSB    = 16;
  localparam int NUM_LSB   = 11;
  localparam int LC_BIT    = 6;
  localparam int DP_BIT    = 5;
  localparam int X_BIT     = 4;
  localparam int D_BIT     = 3;
  localparam int C_BIT     = 2;
  localparam int P_BIT     = 1;
  localparam int E_BIT     = 0;
  localparam int CTRL_W    = 7;
  // value of the low control bits after reset
  localparam logic [6:0] CTRL_RST    = 7'h00;
  // cycle prescaler: one tick per 64 clocks
  localparam int PRESC_DIV = 64;
  localparam int PRESC_W   = 6;
  localparam logic [5:0] PRESC_LAST  = 6'h3F;
  // event counter bank geometry
  localparam int NUM_EVT   = 31;
  localparam int EVT_W     = 32;
  localparam int CYC_W     = 64;
  localparam int IDX_W     = 5;
  // counter index below the hypervisor partition point
  function automatic logic below_partition(input logic [4:0] idx, input logic [4:0] part);
    below_partition = (idx < part);
  endfunction
endpackage

// ==== src/pmc_bank_if.sv ====
// carrier between the control logic and the event counter bank
`timescale 1ns/1ps
`default_nettype none
interface pmc_bank_if;
  logic [30:0] inc;     // one increment per counter this cycle
  logic [30:0] clr;     // zero these counters this cycle
  logic [30:0] ovf;     // one-cycle overflow pulses
  logic [4:0]  rd_idx;  // counter chosen for read back
  logic [31:0] rd_data; // registered read data
  modport bank (input inc, input clr, input rd_idx, output ovf, output rd_data);
  modport ctrl (output inc, output clr, output rd_idx, input ovf, input rd_data);
endinterface
`default_nettype wire

// ==== src/pmc_event_bank.sv ====
// bank of 31 event counters with registered read port and overflow pulses
`timescale 1ns/1ps
`default_nettype none
module pmc_event_bank
(
  input  wire logic clk_sys,
  input  wire logic reset,
  pmc_bank_if.bank  bus
);
  logic [31:0] cnt_r [31];  // counter storage
  logic [30:0] ovf_r;       // overflow pulses
  logic [31:0] rd_r;        // read data register

  // clear wins over increment so a reset is never undone in the same cycle
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < pmc_pkg::NUM_EVT; i++)
    begin
      if (reset || bus.clr[i])
        cnt_r[i] <= 32'h0;
      else if (bus.inc[i])
        cnt_r[i] <= cnt_r[i] + 32'h1;
    end
  end

  // overflow on all-ones wrap, a clear suppresses it
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < pmc_pkg::NUM_EVT; i++)
    begin
      if (reset)
        ovf_r[i] <= 1'b0;
      else
        ovf_r[i] <= bus.inc[i] & ~bus.clr[i] & (cnt_r[i] == 32'hFFFFFFFF);
    end
  end

  // read port, index 31 and above reads zero
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rd_r <= 32'h0;
    else if (bus.rd_idx < 5'h1F)
      rd_r <= cnt_r[bus.rd_idx];
    else
      rd_r <= 32'h0;
  end

  assign bus.ovf     = ovf_r;
  assign bus.rd_data = rd_r;
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking testbench for the performance monitor control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        cp_valid = 1'b0, cp_write = 1'b0;
  logic [3:0]  cp_coproc = 4'hF, cp_crn = 4'h9, cp_crm = 4'hC;
  logic [2:0]  cp_opc1 = 3'h0, cp_opc2 = 3'h0;
  logic [1:0]  cp_el = 2'h2;
  logic [31:0] cp_wdata = 32'h0, cp_rdata, evt_rd_data, overflow_status;
  logic        cp_done, cp_trap_undef, cp_trap_hyp, ext_wr = 1'b0;
  logic [6:0]  ext_wdata = 7'h00, ext_rdata;
  logic        ue = 1'b1, ttpm = 1'b0, ttcr = 1'b0, tt9 = 1'b0, hpmd = 1'b0, cprh = 1'b0;
  logic [4:0]  part = 5'h03, evt_rd_idx = 5'h00;
  logic [31:0] enset = 32'hFFFF_FFFF;
  logic [30:0] event_pulse = 31'h0, event_export;
  logic [63:0] cycle_counter, c0;
  logic [31:0] rd;         // read data of the last access
  logic        tu, th;     // trap flags of the last access
  int          miscompares = 0, n_checks = 0;
  localparam logic [7:0] IMPC = 8'h3C; // arbitrary value
  localparam logic [7:0] IDC  = 8'hC3; // arbitrary value
  localparam logic [23:0] HI  = {IMPC, IDC, 5'h1F, 3'h0};

  pmc_ctrl #(.IMPLEMENTER_CODE(IMPC), .PART_IDENT_CODE(IDC)) pmc_ctrl_i (
    .clk_sys(clk_sys), .reset(reset), .cp_valid(cp_valid), .cp_write(cp_write),
    .cp_coproc(cp_coproc), .cp_opc1(cp_opc1), .cp_crn(cp_crn), .cp_crm(cp_crm),
    .cp_opc2(cp_opc2), .cp_el(cp_el), .cp_wdata(cp_wdata), .cp_done(cp_done),
    .cp_rdata(cp_rdata), .cp_trap_undef(cp_trap_undef), .cp_trap_hyp(cp_trap_hyp),
    .ext_wr(ext_wr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
    .user_access_enable(ue), .hyp_trap_monitor_access(ttpm),
    .hyp_trap_control_access(ttcr), .hyp_trap_primary_nine(tt9),
    .hyp_counter_partition(part), .hyp_prohibit_counting(hpmd), .count_prohibit(cprh),
    .counter_enable_set(enset), .event_pulse(event_pulse), .overflow_clear(32'h0),
    .evt_rd_idx(evt_rd_idx), .evt_rd_data(evt_rd_data), .cycle_counter(cycle_counter),
    .overflow_status(overflow_status), .event_export(event_export));

  // 25 MHz core clock
  always #20 clk_sys = ~clk_sys;

  // compare one value, count it and report a mismatch
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // one coprocessor access; bad selects a wrong secondary register
  task automatic cp(input logic wr, input logic [1:0] el, input logic [31:0] wd, input logic bad);
    @(posedge clk_sys);
    cp_valid <= 1'b1;
    cp_write <= wr;
    cp_el    <= el;
    cp_wdata <= wd;
    cp_crm   <= bad ? 4'hD : pmc_pkg::CP_CRM;
    @(posedge clk_sys);
    cp_valid <= 1'b0;
    #1;
    chk("done", 64'h1, {63'h0, cp_done});
    rd = cp_rdata;
    tu = cp_trap_undef;
    th = cp_trap_hyp;
  endtask

  // cycle counter advance over n clocks
  task automatic meas(input int n, input logic [63:0] e);
    c0 = cycle_counter;
    repeat (n) @(posedge clk_sys);
    #1;
    chk("cycle delta", e, cycle_counter - c0);
  endtask

  // one cycle of event pulses; export seen one cycle late
  task automatic pulse(input logic [30:0] m);
    @(posedge clk_sys);
    event_pulse <= m;
    @(posedge clk_sys);
    event_pulse <= 31'h0;
    #1;
  endtask

  // read back one event counter
  task automatic rde(input logic [4:0] i, input logic [31:0] e);
    @(posedge clk_sys);
    evt_rd_idx <= i;
    @(posedge clk_sys);
    #1;
    chk("event counter", {32'h0, e}, {32'h0, evt_rd_data});
  endtask

  task automatic t_ident;
    cp(0, pmc_pkg::EL_HYP, 0, 0);
    chk("ident hyp", {HI, 8'h0}, rd);
    cp(0, pmc_pkg::EL_KERNEL, 0, 0);
    chk("count kernel", {IMPC, IDC, 5'h03, 11'h0}, rd);
    cp(0, pmc_pkg::EL_USER, 0, 0);
    chk("count user", {IMPC, IDC, 5'h03, 11'h0}, rd);
    $display("test ident done");
  endtask

  task automatic t_bits;
    cp(1, pmc_pkg::EL_HYP, 32'hFFFF_FFFF, 0);
    cp(0, pmc_pkg::EL_HYP, 0, 0);
    chk("ctrl all ones", {HI, 8'h79}, rd);
    chk("debug copy", 64'h79, {57'h0, ext_rdata});
    @(posedge clk_sys);
    ext_wr    <= 1'b1;
    ext_wdata <= 7'h10;
    @(posedge clk_sys);
    ext_wr    <= 1'b0;
    cp(0, pmc_pkg::EL_HYP, 0, 0);
    chk("ctrl from debug", {HI, 8'h10}, rd);
    $display("test control bits done");
  endtask

  task automatic t_cycle;
    cp(1, pmc_pkg::EL_HYP, 32'h01, 0);
    meas(10, 10);
    cp(1, pmc_pkg::EL_HYP, 32'h09, 0);
    meas(128, 2);
    cp(1, pmc_pkg::EL_HYP, 32'h49, 0);
    meas(10, 10);
    cp(1, pmc_pkg::EL_HYP, 32'h05, 0);
    chk("cycle cleared", 64'h0, cycle_counter);
    @(posedge clk_sys);
    cprh <= 1'b1;
    cp(1, pmc_pkg::EL_HYP, 32'h01, 0);
    meas(10, 10);
    cp(1, pmc_pkg::EL_HYP, 32'h21, 0);
    meas(10, 0);
    @(posedge clk_sys);
    cprh <= 1'b0;
    cp(1, pmc_pkg::EL_HYP, 32'h00, 0);
    meas(10, 0);
    $display("test cycle counter done");
  endtask

  task automatic t_export;
    cp(1, pmc_pkg::EL_HYP, 32'h11, 0);
    pulse(31'h4000_0005);
    chk("export on", 64'h4000_0005, {33'h0, event_export});
    cp(1, pmc_pkg::EL_HYP, 32'h01, 0);
    pulse(31'h0000_0005);
    chk("export off", 64'h0, {33'h0, event_export});
    cp(1, pmc_pkg::EL_HYP, 32'h11, 0);
    @(posedge clk_sys);
    cprh <= 1'b1;
    pulse(31'h0000_0005);
    chk("export prohibited", 64'h0, {33'h0, event_export});
    @(posedge clk_sys);
    cprh <= 1'b0;
    $display("test export done");
  endtask

  task automatic t_evclr;
    // counters below the partition belong to the lower levels
    cp(1, pmc_pkg::EL_HYP, 32'h03, 0);
    pulse(31'h7FFF_FFFF);
    pulse(31'h7FFF_FFFF);
    cp(1, pmc_pkg::EL_KERNEL, 32'h03, 0);
    rde(5'h00, 0);
    rde(5'h05, 2);
    cp(1, pmc_pkg::EL_HYP, 32'h03, 0);
    rde(5'h1E, 0);
    // global enable off: only the reserved counters run
    cp(1, pmc_pkg::EL_HYP, 32'h00, 0);
    pulse(31'h7FFF_FFFF);
    rde(5'h00, 0);
    rde(5'h04, 1);
    @(posedge clk_sys);
    hpmd <= 1'b1;
    cp(1, pmc_pkg::EL_HYP, 32'h23, 0);
    pulse(31'h7FFF_FFFF);
    rde(5'h01, 0);
    rde(5'h04, 1);
    meas(10, 0);
    chk("overflow flags", 64'h0, {32'h0, overflow_status});
    @(posedge clk_sys);
    hpmd <= 1'b0;
    $display("test event clear and gating done");
  endtask

  task automatic t_traps;
    @(posedge clk_sys);
    ue <= 1'b0;
    cp(0, pmc_pkg::EL_USER, 0, 0);
    chk("user trap", 64'h2, {62'h0, tu, th});
    @(posedge clk_sys);
    ue <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk_sys);
      {ttpm, ttcr, tt9} <= 3'b100 >> k;
      cp(0, pmc_pkg::EL_KERNEL, 0, 0);
      chk("hyp trap", 64'h1, {62'h0, tu, th});
      chk("trapped data", 64'h0, {32'h0, rd});
    end
    @(posedge clk_sys);
    {ttpm, ttcr, tt9} <= 3'b111;
    cp(0, pmc_pkg::EL_HYP, 0, 0);
    chk("hyp not trapped", 64'h0, {62'h0, tu, th});
    cp(0, pmc_pkg::EL_HYP, 0, 1);
    chk("bad encoding", 64'h2, {62'h0, tu, th});
    @(posedge clk_sys);
    {ttpm, ttcr, tt9} <= 3'b000;
    $display("test traps done");
  endtask

  // the single end of the run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watchdog: the tests need well under 3000 clocks
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    give_verdict();
  end

  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    t_ident();
    t_bits();
    t_cycle();
    t_export();
    t_evclr();
    t_traps();
    give_verdict();
  end
endmodule
`default_nettype wire
